// file: verilog/dsw_status_word.sv
// Purpose: Drive status word and relative speed scaling, APB register bank
// Assumes: Condition inputs are synchronous to i_clk
// Notes:   Zero wait state slave, pready always high

`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Bit 00 is one when control is ready, zero when tripped.
// - Bit 01 is one when drive is ready, even under coast.
// - Bit 02 is zero while coasting, one when start would run.
// - Bit 03 is one while tripped until reset restores operation.
// - Bit 04 is one on an error that causes no trip.
// - Bit 05 is reserved and carries no meaning.
// - Bit 06 is one while tripped and locked.
// - Bit 07 is one whenever any warning is present.
// - Bit 08 is one when motor speed equals reference.
// - Bit 09 is one when bus control is permitted.
// - Bit 10 is one while frequency lies within its limits.
// - Bit 11 is one with start signal and no coast.
// - Bit 12 is one during temporary overtemperature stop.
// - Bit 13 is one when DC link voltage is out of range.
// - Bit 14 is one when motor current exceeds its limit.
// - Bit 15 is one when either thermal timer exceeds 100 percent.
// - Layout applies only when the native drive profile, value 0, is selected.
// - Speed reference is one 16-bit word of full-scale percentage.
// - Integer 16384 represents exactly 100 percent, linear.
// - Negative reference means reverse, in two's complement.
// - Frequency feedback uses the same signed scaling as the reference.
module dsw_status_word
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	input  wire dsw_pkg::dsw_cond_t    i_cond,
	input  wire logic signed [15:0]    i_freq_feedback,
	input  wire dsw_pkg::dsw_apb_req_t i_apb,
	output logic                       o_pready,
	output logic                       o_pslverr,
	output logic [31:0]                o_prdata,
	output logic [15:0]                o_drive_status_word,
	output logic signed [15:0]         o_speed_reference,
	output logic                       o_native_profile
);
	import dsw_pkg::*;

	logic [15:0]        status_d;
	logic [15:0]        status_q;
	logic [7:0]         profile_q;
	logic signed [15:0] speed_ref_q;
	logic signed [15:0] freq_fb_q;
	logic [31:0]        rdata_d;
	logic               wr_en;
	logic               rd_en;
	logic               addr_ok;

	// Scale a signed relative word to whole percent, truncated toward zero
	function automatic logic signed [15:0] dsw_to_pct(input logic signed [15:0] w);
		logic signed [31:0] prod;
		prod = 32'(w) * 32'(DSW_PCT_100);
		return 16'(prod / 32'(DSW_FULL_SCALE));
	endfunction

	// Bus decode, zero wait states
	assign o_pready  = 1'b1;
	assign wr_en     = i_apb.psel & i_apb.penable & i_apb.pwrite;
	assign rd_en     = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
	assign addr_ok   = (i_apb.paddr == DSW_OFF_STATUS) | (i_apb.paddr == DSW_OFF_PROFILE)
		| (i_apb.paddr == DSW_OFF_SPEEDREF) | (i_apb.paddr == DSW_OFF_FREQFB)
		| (i_apb.paddr == DSW_OFF_SPDPCT) | (i_apb.paddr == DSW_OFF_FBPCT);
	assign o_pslverr = i_apb.psel & i_apb.penable & ~addr_ok;
	assign o_native_profile = (profile_q == DSW_PROFILE_NATIVE);

	// Status word assembly from drive conditions
	always_comb
	begin
		status_d = DSW_WORD_RST;
		status_d[DSW_B_CTRL_RDY]  = i_cond.control_ready & ~i_cond.tripped;
		status_d[DSW_B_DRV_RDY]   = i_cond.drive_ready;
		status_d[DSW_B_ENABLE]    = ~i_cond.motor_released;
		status_d[DSW_B_TRIP]      = i_cond.tripped;
		status_d[DSW_B_ERROR]     = i_cond.error_no_trip;
		status_d[DSW_B_RSVD]      = 1'b0;
		status_d[DSW_B_TRIPLOCK]  = i_cond.triplock;
		status_d[DSW_B_WARNING]   = i_cond.warning_any;
		status_d[DSW_B_SPD_MATCH] = i_cond.speed_eq_ref;
		status_d[DSW_B_BUS_CTRL]  = ~i_cond.local_or_off;
		status_d[DSW_B_FREQ_OK]   = ~(i_cond.freq_at_low_limit | i_cond.freq_at_high_limit);
		status_d[DSW_B_RUNNING]   = i_cond.start_no_coast;
		status_d[DSW_B_AUTO_STOP] = i_cond.overtemp_auto_stop;
		status_d[DSW_B_VOLT_EXC]  = i_cond.dc_under | i_cond.dc_over;
		status_d[DSW_B_CURR_EXC]  = i_cond.current_over_limit;
		status_d[DSW_B_THERM_EXC] = i_cond.therm_timer_a_over | i_cond.therm_timer_b_over;
		if (profile_q != DSW_PROFILE_NATIVE)
		begin
			status_d = DSW_WORD_RST;
		end
	end

	// Status word register, updated every clock
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			status_q <= DSW_WORD_RST;
		else
			status_q <= status_d;
	end

	// Frequency feedback word, same scaling as the reference
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			freq_fb_q <= 16'sh0000;
		else
			freq_fb_q <= i_freq_feedback;
	end

	// Protocol selection register
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			profile_q <= DSW_PROFILE_RST;
		else if (wr_en && i_apb.paddr == DSW_OFF_PROFILE)
			profile_q <= i_apb.pwdata[7:0];
	end

	// Bus speed reference, one signed 16-bit word
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			speed_ref_q <= 16'sh0000;
		else if (wr_en && i_apb.paddr == DSW_OFF_SPEEDREF)
			speed_ref_q <= i_apb.pwdata[15:0];
	end

	// Read mux
	always_comb
	begin
		rdata_d = DSW_RDATA_ZERO;
		unique case (i_apb.paddr)
			DSW_OFF_STATUS:   rdata_d = {16'h0000, status_q};
			DSW_OFF_PROFILE:  rdata_d = {24'h000000, profile_q};
			DSW_OFF_SPEEDREF: rdata_d = {16'h0000, speed_ref_q};
			DSW_OFF_FREQFB:   rdata_d = {16'h0000, freq_fb_q};
			DSW_OFF_SPDPCT:   rdata_d = {16'h0000, dsw_to_pct(speed_ref_q)};
			DSW_OFF_FBPCT:    rdata_d = {16'h0000, dsw_to_pct(freq_fb_q)};
			default:          rdata_d = DSW_RDATA_ZERO;
		endcase
	end

	// Read data captured in the setup cycle, held through access
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_prdata <= DSW_RDATA_ZERO;
		else if (rd_en)
			o_prdata <= rdata_d;
	end

	assign o_drive_status_word = status_q;
	assign o_speed_reference   = speed_ref_q;

	// Checks
	// Status bit checks look one edge back at the conditions. The edge right after a
	// reset release still shows the reset word, so each check that can require a one wants the previous
	// edge to have been out of reset; otherwise a level held through reset would fire.
	a_trip_bit_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && o_native_profile && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_TRIP] == $past(i_cond.tripped))
		else $error("trip bit mismatch");
	a_ctrl_ready_trip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_cond.tripped) |-> !o_drive_status_word[DSW_B_CTRL_RDY])
		else $error("control ready set while tripped");
	a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_drive_status_word[DSW_B_RSVD] == 1'b0)
		else $error("reserved bit set");
	a_volt_range_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(i_cond.dc_under) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_VOLT_EXC])
		else $error("voltage bit missing");
	a_therm_timer_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(i_cond.therm_timer_b_over) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_THERM_EXC])
		else $error("thermal bit missing");
	a_freq_limit_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_cond.freq_at_high_limit) |-> !o_drive_status_word[DSW_B_FREQ_OK])
		else $error("frequency ok while at limit");
	a_profile_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!$past(o_native_profile) |-> o_drive_status_word == DSW_WORD_RST)
		else $error("status word live under other profile");
	a_bus_ctrl_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_rst_b) |-> (($past(i_cond.local_or_off) || !$past(o_native_profile))
		== !o_drive_status_word[DSW_B_BUS_CTRL]))
		else $error("bus control bit wrong");
	a_speed_ref_wr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(wr_en && i_apb.paddr == DSW_OFF_SPEEDREF) |=> o_speed_reference == $past(i_apb.pwdata[15:0]))
		else $error("speed reference not stored");
	a_fb_copy: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_rst_b) |-> freq_fb_q == $past(i_freq_feedback))
		else $error("feedback not registered");

	// Remaining status bits, each against the condition seen one edge earlier

	// Control ready shows when control is up and no trip is pending
	a_ctrl_ready_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile) && $past(i_cond.control_ready)
		&& !$past(i_cond.tripped)) |-> o_drive_status_word[DSW_B_CTRL_RDY])
		else $error("control ready bit missing");

	// Drive ready is independent of any coast request
	a_drv_ready_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_DRV_RDY] == $past(i_cond.drive_ready))
		else $error("drive ready bit wrong");

	// Enable bit is the inverse of the motor being released
	a_enable_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_ENABLE] == !$past(i_cond.motor_released))
		else $error("enable bit wrong");

	// Error without trip
	a_error_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_ERROR] == $past(i_cond.error_no_trip))
		else $error("error bit wrong");

	// Trip and lock
	a_triplock_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_TRIPLOCK] == $past(i_cond.triplock))
		else $error("triplock bit wrong");

	// Any warning
	a_warning_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_WARNING] == $past(i_cond.warning_any))
		else $error("warning bit wrong");

	// Speed matches reference, low while ramping
	a_speed_match_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_SPD_MATCH] == $past(i_cond.speed_eq_ref))
		else $error("speed match bit wrong");

	// Frequency low limit also clears the in-range bit
	a_freq_low_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_cond.freq_at_low_limit) |-> !o_drive_status_word[DSW_B_FREQ_OK])
		else $error("frequency ok while at low limit");

	// In range when neither limit is reached
	a_freq_ok_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile) && !$past(i_cond.freq_at_low_limit)
		&& !$past(i_cond.freq_at_high_limit)) |-> o_drive_status_word[DSW_B_FREQ_OK])
		else $error("frequency ok bit missing");

	// Start without coast
	a_running_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_RUNNING] == $past(i_cond.start_no_coast))
		else $error("running bit wrong");

	// Temporary overtemperature stop
	a_auto_stop_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_AUTO_STOP] == $past(i_cond.overtemp_auto_stop))
		else $error("auto stop bit wrong");

	// DC link too high also raises the voltage bit
	a_volt_high_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(i_cond.dc_over) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_VOLT_EXC])
		else $error("voltage bit missing on high link");

	// Voltage bit quiet while the link is in range
	a_volt_clear_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!$past(i_cond.dc_under) && !$past(i_cond.dc_over))
		|-> !o_drive_status_word[DSW_B_VOLT_EXC])
		else $error("voltage bit set in range");

	// Current limit
	a_current_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_CURR_EXC] == $past(i_cond.current_over_limit))
		else $error("current bit wrong");

	// The first thermal timer also raises the thermal bit
	a_therm_a_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $past(i_cond.therm_timer_a_over) && $past(o_native_profile))
		|-> o_drive_status_word[DSW_B_THERM_EXC])
		else $error("thermal bit missing on first timer");

	// Thermal bit quiet while both timers are within bounds
	a_therm_clear_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!$past(i_cond.therm_timer_a_over) && !$past(i_cond.therm_timer_b_over))
		|-> !o_drive_status_word[DSW_B_THERM_EXC])
		else $error("thermal bit set within bounds");

	// The word leaves reset cleared, whatever the conditions were
	a_status_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!$past(i_rst_b) |-> o_drive_status_word == DSW_WORD_RST)
		else $error("status word not cleared by reset");

	// Protocol selection follows the last write to it
	a_profile_wr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(wr_en && i_apb.paddr == DSW_OFF_PROFILE)
		|=> o_native_profile == ($past(i_apb.pwdata[7:0]) == DSW_PROFILE_NATIVE))
		else $error("profile select not stored");

	// Speed reference holds between writes
	a_speed_ref_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && !($past(wr_en) && $past(i_apb.paddr) == DSW_OFF_SPEEDREF))
		|-> $stable(o_speed_reference))
		else $error("speed reference moved without a write");

	// Read data only moves on a read setup, so the master sees it stand
	a_prdata_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && !$past(rd_en)) |-> $stable(o_prdata))
		else $error("read data moved outside a read");

	// Full scale reads as one hundred percent
	a_pct_full: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(speed_ref_q == DSW_FULL_SCALE) |-> dsw_to_pct(speed_ref_q) == DSW_PCT_100)
		else $error("full scale not one hundred percent");

	// A reverse reference never reads as a positive percentage
	a_pct_sign: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		speed_ref_q[15] |-> dsw_to_pct(speed_ref_q) <= 16'sh0000)
		else $error("reverse reference gives positive percent");

endmodule

`default_nettype wire

// file: common/dsw_pkg.sv
// Purpose: Shared constants and types for the drive status word block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Offsets are byte addresses

package dsw_pkg;

	// Register byte offsets
	localparam logic [7:0] DSW_OFF_STATUS   = 8'h00;
	localparam logic [7:0] DSW_OFF_PROFILE  = 8'h04;
	localparam logic [7:0] DSW_OFF_SPEEDREF = 8'h08;
	localparam logic [7:0] DSW_OFF_FREQFB   = 8'h0c;
	localparam logic [7:0] DSW_OFF_SPDPCT   = 8'h10;
	localparam logic [7:0] DSW_OFF_FBPCT    = 8'h14;

	// Status word bit positions
	localparam int DSW_B_CTRL_RDY  = 0;
	localparam int DSW_B_DRV_RDY   = 1;
	localparam int DSW_B_ENABLE    = 2;
	localparam int DSW_B_TRIP      = 3;
	localparam int DSW_B_ERROR     = 4;
	localparam int DSW_B_RSVD      = 5;
	localparam int DSW_B_TRIPLOCK  = 6;
	localparam int DSW_B_WARNING   = 7;
	localparam int DSW_B_SPD_MATCH = 8;
	localparam int DSW_B_BUS_CTRL  = 9;
	localparam int DSW_B_FREQ_OK   = 10;
	localparam int DSW_B_RUNNING   = 11;
	localparam int DSW_B_AUTO_STOP = 12;
	localparam int DSW_B_VOLT_EXC  = 13;
	localparam int DSW_B_CURR_EXC  = 14;
	localparam int DSW_B_THERM_EXC = 15;

	// Scaling: 16384 is 100 percent
	localparam logic signed [15:0] DSW_FULL_SCALE = 16'sh4000;
	localparam logic signed [15:0] DSW_PCT_100    = 16'sh0064;
	localparam logic [7:0]  DSW_PROFILE_NATIVE = 8'h00;
	localparam logic [7:0]  DSW_PROFILE_RST    = 8'h00;
	localparam logic [15:0] DSW_WORD_RST       = 16'h0000;
	localparam logic [31:0] DSW_RDATA_ZERO     = 32'h0000_0000;

	// Raw drive conditions feeding the status word
	typedef struct packed {
		logic therm_timer_a_over;
		logic therm_timer_b_over;
		logic current_over_limit;
		logic dc_under;
		logic dc_over;
		logic overtemp_auto_stop;
		logic start_no_coast;
		logic freq_at_low_limit;
		logic freq_at_high_limit;
		logic local_or_off;
		logic speed_eq_ref;
		logic warning_any;
		logic triplock;
		logic error_no_trip;
		logic tripped;
		logic motor_released;
		logic drive_ready;
		logic control_ready;
	} dsw_cond_t;

	// APB request
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dsw_apb_req_t;

endpackage

// file: bench/dsw_master_model.sv
// Purpose: APB master standing for the fieldbus side of the status block
// Assumes: Slave completes when pready is high in the access phase
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module dsw_master_model
(
	input  wire logic             i_clk,
	input  wire logic             i_pready,
	input  wire logic             i_pslverr,
	input  wire logic [31:0]      i_prdata,
	output var dsw_pkg::dsw_apb_req_t o_apb
);
	import dsw_pkg::*;

	initial o_apb = '0;

	// One transfer: setup, access until pready, then release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge i_clk);
		o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge i_clk);
		o_apb.penable <= 1'b1;
		@(posedge i_clk);
		while (i_pready !== 1'b1)
			@(posedge i_clk);
		q = i_prdata;
		e = i_pslverr;
		o_apb <= '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0, paddr: ~a, pwdata: ~d};
	endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for the drive status word block
// Assumes: Zero wait state APB slave
// Notes:   Walks every condition input and several speed values
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dsw_pkg::*;
	logic               i_clk = 1'b0;
	logic               i_rst_b = 1'b0;
	dsw_cond_t          cond = '0;
	logic signed [15:0] fb = '0;
	dsw_apb_req_t       apb;
	logic               pready;
	logic               pslverr;
	logic               nat;
	logic [31:0]        prdata;
	logic [15:0]        drive_status_word;
	logic signed [15:0] spd;
	logic [31:0]        q;
	logic               e;
	int                 miscompares = 0;
	int                 tests_run = 0;
	int                 cycles = 0;
	logic signed [15:0] vals [4] = '{16'sh4000, 16'shc000, 16'sh7fff, 16'shffff};

	always #5 i_clk = ~i_clk;

	dsw_status_word u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cond(cond),
		.i_freq_feedback(fb), .i_apb(apb), .o_pready(pready), .o_pslverr(pslverr),
		.o_prdata(prdata), .o_drive_status_word(drive_status_word), .o_speed_reference(spd),
		.o_native_profile(nat));
	dsw_master_model u_mst (.i_clk(i_clk), .i_pready(pready), .i_pslverr(pslverr),
		.i_prdata(prdata), .o_apb(apb));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			miscompares++;
		end
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		u_mst.xfer(1'b0, a, 32'h0000_0000, q, e);
		chk(nm, q, exp);
	endtask

	task automatic conclude;
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Expected status word worked out from the condition levels
	function automatic logic [15:0] expw(dsw_cond_t c);
		return {c.therm_timer_a_over | c.therm_timer_b_over, c.current_over_limit,
			c.dc_under | c.dc_over, c.overtemp_auto_stop, c.start_no_coast,
			!(c.freq_at_low_limit | c.freq_at_high_limit), !c.local_or_off,
			c.speed_eq_ref, c.warning_any, c.triplock, 1'b0, c.error_no_trip,
			c.tripped, !c.motor_released, c.drive_ready, c.control_ready & !c.tripped};
	endfunction

	// Percent of full scale, truncated toward zero
	function automatic logic [15:0] pct(logic signed [15:0] v);
		int p;
		p = int'(v) * 100 / int'(DSW_FULL_SCALE);
		return p[15:0];
	endfunction

	// Hang guard
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			conclude();
		end
	end

	initial
	begin
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rdchk("profile_rst", DSW_OFF_PROFILE, 32'h0000_0000);
		chk("native_rst", nat, 1'b1);
		// Walking one over each condition, then all set
		for (int k = 0; k < 19; k++)
		begin
			@(posedge i_clk);
			cond <= (k == 18) ? dsw_cond_t'('1) : dsw_cond_t'(18'h1 << k);
			repeat (2) @(posedge i_clk);
			rdchk("status", DSW_OFF_STATUS, {16'h0000, expw(cond)});
			chk("status_port", drive_status_word, expw(cond));
			chk("status_err", e, 1'b0);
		end
		// Non-native profile hides the layout
		u_mst.xfer(1'b1, DSW_OFF_PROFILE, 32'h0000_0001, q, e);
		rdchk("status_other", DSW_OFF_STATUS, 32'h0000_0000);
		chk("native_other", nat, 1'b0);
		u_mst.xfer(1'b1, DSW_OFF_PROFILE, 32'h0000_0000, q, e);
		rdchk("status_back", DSW_OFF_STATUS, {16'h0000, expw(cond)});
		// Speed reference and feedback scaling, including the sign
		foreach (vals[i])
		begin
			u_mst.xfer(1'b1, DSW_OFF_SPEEDREF, {16'h0000, vals[i]}, q, e);
			fb <= vals[3 - i];
			rdchk("spd", DSW_OFF_SPEEDREF, {16'h0000, vals[i]});
			chk("spd_port", spd, vals[i]);
			rdchk("spd_pct", DSW_OFF_SPDPCT, {16'h0000, pct(vals[i])});
			rdchk("fb", DSW_OFF_FREQFB, {16'h0000, fb});
			rdchk("fb_pct", DSW_OFF_FBPCT, {16'h0000, pct(fb)});
		end
		// Read-only feedback ignores writes; unmapped place is refused
		u_mst.xfer(1'b1, DSW_OFF_FREQFB, 32'h0000_1234, q, e);
		rdchk("fb_ro", DSW_OFF_FREQFB, {16'h0000, fb});
		rdchk("unmapped", 8'h18, 32'h0000_0000);
		chk("unmapped_err", e, 1'b1);
		// Reset in mid-run with every condition still raised
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rdchk("spd_rst", DSW_OFF_SPEEDREF, 32'h0000_0000);
		rdchk("status_rst", DSW_OFF_STATUS, {16'h0000, expw(cond)});
		conclude();
	end
endmodule
`default_nettype wire
